// [design/mmia_defs.vh]
// Constants for the management-port slave with indirect extended access.
// Included by every design file of the block; definitions only.
`ifndef MMIA_DEFS_VH
`define MMIA_DEFS_VH

// Frame fields
`define MMIA_START_CODE     2'h1
`define MMIA_OP_READ        2'h2
`define MMIA_OP_WRITE       2'h1
`define MMIA_TA_WRITE       2'h2
`define MMIA_HEADER_BITS    6'h20

// Direct register offsets
`define MMIA_REG_ACCESS_CTRL 5'h0D
`define MMIA_REG_ADDR_DATA   5'h0E

// Access-control fields
`define MMIA_SEL_LSB        0
`define MMIA_SEL_MSB        4
`define MMIA_FUNC_LSB       14
`define MMIA_FUNC_MSB       15
`define MMIA_SEL_VALID      5'h1F
`define MMIA_FUNC_ADDR      2'h0
`define MMIA_FUNC_DATA      2'h1
`define MMIA_FUNC_INC_RW    2'h2
`define MMIA_FUNC_INC_W     2'h3

// Extended register with a side effect
`define MMIA_EXT_CLKOUT     16'h0170
`define MMIA_EXT_CLKOUT_RST 16'h0C10
`define MMIA_EXT_CLKOUT_OFF 16'h0C50
`define MMIA_EXT_DEPTH      64
`define MMIA_EXT_IDX_BITS   6

// Reset values
`define MMIA_DIRECT_RST     16'h0000

`endif

// [design/mmia_ext_regs.v]
// Extended register space reached through the indirect path.
// Assumes writes are single-cycle strobes from the frame logic; reads are combinational.
`default_nettype none
`include "mmia_defs.vh"

module mmia_ext_regs (
    // Clock and control
    input  wire        clock,
    input  wire        reset,
    input  wire        clockEnable,
    // Access
    input  wire [15:0] extAddress,
    input  wire        writeStrobe,
    input  wire [15:0] writeData,
    output wire [15:0] readData,
    // Side effect
    output reg         clockOutEnable
);

    // Only a small window is stored; the rest reads zero and drops writes
    localparam [15:0] CLK_FULL = `MMIA_EXT_CLKOUT;
    localparam [`MMIA_EXT_IDX_BITS-1:0] CLK_IDX = CLK_FULL[`MMIA_EXT_IDX_BITS-1:0];
    reg  [15:0] extMem [0:`MMIA_EXT_DEPTH-1];
    wire        inWindow = (extAddress[15:`MMIA_EXT_IDX_BITS] ==
                            CLK_FULL[15:`MMIA_EXT_IDX_BITS]);
    wire [`MMIA_EXT_IDX_BITS-1:0] index = extAddress[`MMIA_EXT_IDX_BITS-1:0];

    genvar g;
    generate
        for (g = 0; g < `MMIA_EXT_DEPTH; g = g + 1) begin : gEntry
            always @(posedge clock) begin
                if (reset) begin
                    extMem[g] <= (g == CLK_IDX) ? `MMIA_EXT_CLKOUT_RST : 16'h0000;
                end else if (clockEnable && writeStrobe && inWindow && index == g) begin
                    extMem[g] <= writeData;
                end
            end
        end
    endgenerate

    assign readData = inWindow ? extMem[index] : 16'h0000;

    always @(posedge clock) begin
        if (reset) begin
            clockOutEnable <= 1'b1;
        end else if (clockEnable) begin
            clockOutEnable <= (extMem[CLK_IDX] != `MMIA_EXT_CLKOUT_OFF); // see [RULE19]
        end
    end

endmodule
`default_nettype wire

// [design/mmia_mdio_slave.v]
// Management-port slave: frame decoder, 32 direct registers, indirect path.
// Assumes MDC and MDIO are asynchronous pins; clock is much faster than MDC.
//
// Overview of operation
// [RULE1] Frame: idle, start 01, opcode 10 read / 01 write, addresses, turnaround, 16 data.
// [RULE2] Data line sampled on the management clock's rising edge; clock may stop.
// [RULE3] Read: first turnaround bit undriven, device drives 0 then data; write uses 10.
// [RULE4] Bus address latched from straps at reset; only matching frames answered.
// [RULE5] Station keeps the bus idle one clock cycle after reset release.
// [RULE6] Indirect access via access-control 0x0D and address/data 0x0E registers.
// [RULE7] Direct registers reachable indirectly, except 0x0D and 0x0E which are ignored.
// [RULE8] Access-control bits 4:0 select the target device for address/data accesses.
// [RULE9] Only selector 11111 implemented; address/data accesses otherwise ignored.
// [RULE10] Bits 15:14 pick function: address, data, increment both, increment writes.
// [RULE11] Function 00: address/data accesses act on the extended address register.
// [RULE12] Station loads the address register before data-function accesses.
// [RULE13] Function 01: access extended register at address, address unchanged.
// [RULE14] Function 10: address increments after every completed read or write.
// [RULE15] Function 11: address increments after writes only, not reads.
// [RULE16] Unincremented write: 0x001F, address, 0x401F, then data.
// [RULE17] Burst: 0x801F or 0xC01F after loading address, then repeated accesses.
// [RULE18] Station may skip address steps if address register already holds it.
// [RULE19] Extended 0x0170 resets to 0x0C10; writing 0x0C50 disables clock output.
// [RULE20] Data line released except second turnaround bit and read data bits.
`default_nettype none
`include "mmia_defs.vh"

module mmia_mdio_slave (
    // Clock and control
    input  wire        clock,
    input  wire        reset,
    input  wire        clockEnable,
    // Straps
    input  wire [4:0]  busAddressStraps,
    // Management pins
    input  wire        mgmtClock,
    input  wire        mgmtDataIn,
    output reg         mgmtDataOut,
    output reg         mgmtDataOutEnable_n,
    // Device side
    output wire        clockOutEnable
);

    // Frame states
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_HEAD  = 5'h02;
    localparam [4:0] ST_TURN  = 5'h04;
    localparam [4:0] ST_DATA  = 5'h08;
    localparam [4:0] ST_WDATA = 5'h10;

    wire        mdcSync;
    wire        mdioSync;
    reg         mdcLast;
    reg  [4:0]  state;
    reg  [5:0]  bitCount;
    reg  [13:0] header;
    reg  [15:0] shiftReg;
    reg  [4:0]  myAddress;
    reg         strapTaken;
    reg  [15:0] directRegs [0:31];
    reg  [15:0] extAddress;
    reg         turnSecond;

    // Both pins pass two flops before any logic sees them
    mmia_sync uSyncMdc (
        .clock       (clock),
        .reset       (reset),
        .clockEnable (clockEnable),
        .asyncIn     (mgmtClock),
        .syncOut     (mdcSync)
    );
    mmia_sync uSyncMdio (
        .clock       (clock),
        .reset       (reset),
        .clockEnable (clockEnable),
        .asyncIn     (mgmtDataIn),
        .syncOut     (mdioSync)
    );

    wire mdcRise = mdcSync & ~mdcLast; // see [RULE2]
    wire mdcFall = ~mdcSync & mdcLast;

    // Decoded header: 01 op(2) phy(5) reg(5); header holds the second start bit and the 12 bits after it
    wire [1:0]  opCode    = header[11:10];
    wire [4:0]  phyField  = header[9:5];
    wire [4:0]  regField  = header[4:0];
    wire        addressed = (phyField == myAddress); // see [RULE4]
    wire        isRead    = (opCode == `MMIA_OP_READ);
    wire        isWrite   = (opCode == `MMIA_OP_WRITE);

    // Indirect path decode
    wire [15:0] accessCtrl = directRegs[`MMIA_REG_ACCESS_CTRL];
    wire [1:0]  func       = accessCtrl[`MMIA_FUNC_MSB:`MMIA_FUNC_LSB]; // see [RULE10]
    wire        selValid   = (accessCtrl[`MMIA_SEL_MSB:`MMIA_SEL_LSB] == `MMIA_SEL_VALID); // see [RULE8] [RULE9]
    wire        isAddrData = (regField == `MMIA_REG_ADDR_DATA);
    // Extended addresses 0..31 alias the direct registers, bar 0x0D and 0x0E
    wire        extIsDirect = (extAddress[15:5] == 11'h000);
    wire        extIsWindow = extIsDirect &&
                              (extAddress[4:0] == `MMIA_REG_ACCESS_CTRL ||
                               extAddress[4:0] == `MMIA_REG_ADDR_DATA); // see [RULE7]

    wire [15:0] extReadData;
    reg  [15:0] indirectRead;
    reg  [15:0] readValue;
    reg         extWrite;
    reg  [15:0] extWriteData;

    mmia_ext_regs uExt (
        .clock          (clock),
        .reset          (reset),
        .clockEnable    (clockEnable),
        .extAddress     (extAddress),
        .writeStrobe    (extWrite),
        .writeData      (extWriteData),
        .readData       (extReadData),
        .clockOutEnable (clockOutEnable)
    );

    // Value returned for a read of the addressed register
    always @* begin
        if (extIsWindow) begin
            indirectRead = 16'h0000;
        end else if (extIsDirect) begin
            indirectRead = directRegs[extAddress[4:0]];
        end else begin
            indirectRead = extReadData;
        end
        if (!isAddrData) begin
            readValue = directRegs[regField];
        end else if (!selValid) begin
            readValue = 16'h0000; // see [RULE9]
        end else if (func == `MMIA_FUNC_ADDR) begin
            readValue = extAddress; // see [RULE11]
        end else begin
            readValue = indirectRead; // see [RULE13]
        end
    end

    // Frame completion strobes
    wire frameDone  = clockEnable && mdcRise && state == ST_DATA && bitCount == 6'h0F;
    wire writeDone  = clockEnable && mdcRise && state == ST_WDATA && bitCount == 6'h0F;
    wire [15:0] wordIn = {shiftReg[14:0], mdioSync};
    wire doWrite    = writeDone && addressed;
    wire doRead     = frameDone && addressed;
    wire indirWrite = doWrite && isAddrData && selValid;
    wire indirRead  = doRead && isAddrData && selValid;

    always @* begin
        extWrite     = indirWrite && func != `MMIA_FUNC_ADDR && !extIsDirect;
        extWriteData = wordIn;
    end

    // Strap capture after reset release, never inside the reset branch
    always @(posedge clock) begin
        if (reset) begin
            strapTaken <= 1'b0;
            myAddress  <= 5'h00;
        end else if (clockEnable && !strapTaken) begin
            strapTaken <= 1'b1;
            myAddress  <= busAddressStraps; // see [RULE4]
        end
    end

    // Frame sequencer
    always @(posedge clock) begin
        if (reset) begin
            state    <= ST_IDLE;
            bitCount <= 6'h00;
            header   <= 14'h0000;
            shiftReg <= 16'h0000;
            // Matches the synchroniser's reset level, so no false rising edge after reset
            mdcLast  <= 1'b1;
        end else if (clockEnable) begin
            mdcLast <= mdcSync;
            if (mdcRise) begin
                case (state)
                    ST_IDLE: begin
                        // A zero after idle ones opens the start code
                        if (!mdioSync) begin
                            state    <= ST_HEAD;
                            bitCount <= 6'h00;
                        end
                    end
                    ST_HEAD: begin
                        header   <= {header[12:0], mdioSync};
                        bitCount <= bitCount + 6'h01;
                        if (bitCount == 6'h00 && !mdioSync) begin
                            state <= ST_IDLE; // see [RULE1]
                        end else if (bitCount == 6'h0C) begin
                            state    <= ST_TURN;
                            bitCount <= 6'h00;
                        end
                    end
                    ST_TURN: begin
                        bitCount <= bitCount + 6'h01;
                        if (bitCount == 6'h01) begin
                            bitCount <= 6'h00;
                            if (isRead) begin
                                state    <= ST_DATA;
                                shiftReg <= readValue;
                            end else if (isWrite) begin
                                state <= ST_WDATA;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_DATA: begin
                        shiftReg <= {shiftReg[14:0], 1'b0};
                        bitCount <= bitCount + 6'h01;
                        if (bitCount == 6'h0F) begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_WDATA: begin
                        shiftReg <= wordIn;
                        bitCount <= bitCount + 6'h01;
                        if (bitCount == 6'h0F) begin
                            state <= ST_IDLE;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Direct registers; window writes ignored via indirect path
    genvar r;
    generate
        for (r = 0; r < 32; r = r + 1) begin : gDirect
            always @(posedge clock) begin
                if (reset) begin
                    directRegs[r] <= `MMIA_DIRECT_RST;
                end else if (doWrite && !isAddrData && regField == r) begin
                    directRegs[r] <= wordIn; // see [RULE6]
                end else if (indirWrite && func != `MMIA_FUNC_ADDR && extIsDirect
                             && !extIsWindow && extAddress[4:0] == r) begin
                    directRegs[r] <= wordIn; // see [RULE7]
                end
            end
        end
    endgenerate

    // Extended address register and post-increment
    always @(posedge clock) begin
        if (reset) begin
            extAddress <= 16'h0000;
        end else if (indirWrite && func == `MMIA_FUNC_ADDR) begin
            extAddress <= wordIn; // see [RULE11]
        end else if ((indirWrite && func == `MMIA_FUNC_INC_RW) ||
                     (indirRead && func == `MMIA_FUNC_INC_RW)) begin
            extAddress <= extAddress + 16'h0001; // see [RULE14]
        end else if (indirWrite && func == `MMIA_FUNC_INC_W) begin
            extAddress <= extAddress + 16'h0001; // see [RULE15]
        end
    end

    // Pin drive changes on the falling edge so the station samples stable data
    always @(posedge clock) begin
        if (reset) begin
            mgmtDataOut         <= 1'b1;
            mgmtDataOutEnable_n <= 1'b1;
            turnSecond          <= 1'b0;
        end else if (clockEnable && mdcFall) begin
            turnSecond <= 1'b0;
            if (state == ST_TURN && bitCount == 6'h01 && isRead && addressed) begin
                mgmtDataOut         <= 1'b0; // see [RULE3]
                mgmtDataOutEnable_n <= 1'b0;
                turnSecond          <= 1'b1;
            end else if (state == ST_DATA && addressed) begin
                mgmtDataOut         <= shiftReg[15];
                mgmtDataOutEnable_n <= 1'b0;
            end else begin
                mgmtDataOut         <= 1'b1; // see [RULE20]
                mgmtDataOutEnable_n <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// [design/mmia_sync.v]
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the destination clock samples an input slower than itself.
`default_nettype none
`include "mmia_defs.vh"

module mmia_sync (
    // Clock and control
    input  wire clock,
    input  wire reset,
    input  wire clockEnable,
    // Level in and out
    input  wire asyncIn,
    output reg  syncOut
);

    reg firstStage;

    // Reset to idle-high, matching the pulled-up line
    always @(posedge clock) begin
        if (reset) begin
            firstStage <= 1'b1;
            syncOut    <= 1'b1;
        end else if (clockEnable) begin
            firstStage <= asyncIn;
            syncOut    <= firstStage;
        end
    end

endmodule
`default_nettype wire

// [dv/mmia_mdio_slave_asserts.sv]
// Checker for the management-port slave; sees its top ports only.
// Assumes a management half period spans several system clocks.
`default_nettype none
module mmia_mdio_slave_asserts (
    // Clock and control
    input wire logic       clock,
    input wire logic       reset,
    input wire logic       clockEnable,
    input wire logic [4:0] busAddressStraps,
    // Pins
    input wire logic       mgmtClock,
    input wire logic       mgmtDataIn,
    input wire logic       mgmtDataOut,
    input wire logic       mgmtDataOutEnable_n,
    input wire logic       clockOutEnable
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       mdcLast;
    logic [4:0] fallCount;
    logic [3:0] sinceFall;
    wire        mdcFall = mdcLast && !mgmtClock;
    // Falls seen while driving: sixteen data bits plus the fall that releases the line
    always_ff @(posedge clock) begin
        mdcLast <= mgmtClock;
        if (reset || mgmtDataOutEnable_n)
            fallCount <= 5'h00;
        else if (mdcFall)
            fallCount <= fallCount + 5'h01;
        if (reset)
            sinceFall <= 4'hF;
        else if (mdcFall)
            sinceFall <= 4'h0;
        else if (sinceFall != 4'hF)
            sinceFall <= sinceFall + 4'h1;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    a_reset_idle: assert property ($fell(reset) |-> mgmtDataOutEnable_n && clockOutEnable)
        else $error("outputs not idle after reset");
    // Line was still released, pulled high, just before the drive began
    a_ta_released: assert property ($fell(mgmtDataOutEnable_n) |-> $past(mgmtDataIn))
        else $error("line driven low before second turnaround bit");
    a_ta_zero: assert property ($fell(mgmtDataOutEnable_n) |-> (!mgmtDataOut && !mgmtDataOutEnable_n) [*6])
        else $error("second turnaround bit not zero");
    a_read_length: assert property ($rose(mgmtDataOutEnable_n) |-> fallCount == 5'd17)
        else $error("read drive not seventeen bit times");
    a_count_bound: assert property (fallCount <= 5'd17)
        else $error("line driven past read data");
    a_enable_on_fall: assert property ($changed(mgmtDataOutEnable_n) |-> sinceFall <= 4'd7)
        else $error("drive enable moved away from a clock fall");
    a_data_on_fall: assert property (!mgmtDataOutEnable_n && $changed(mgmtDataOut) |-> sinceFall <= 4'd7)
        else $error("read data moved away from a clock fall");
    a_clkout_quiet: assert property ($fell(clockOutEnable) |-> mgmtDataOutEnable_n ##1 !clockOutEnable [*8])
        else $error("clock output dropped during a read");
    c_read: cover property ($rose(mgmtDataOutEnable_n) && fallCount == 5'd17);
    c_drive: cover property ($fell(mgmtDataOutEnable_n));
    c_clkout: cover property ($fell(clockOutEnable));
endmodule
bind mmia_mdio_slave mmia_mdio_slave_asserts u_mmia_mdio_slave_asserts (
    .clock              (clock),
    .reset              (reset),
    .clockEnable        (clockEnable),
    .busAddressStraps   (busAddressStraps),
    .mgmtClock          (mgmtClock),
    .mgmtDataIn         (mgmtDataIn),
    .mgmtDataOut        (mgmtDataOut),
    .mgmtDataOutEnable_n(mgmtDataOutEnable_n),
    .clockOutEnable     (clockOutEnable)
);
`default_nettype wire

// [dv/mmia_mdio_slave_tb_top.sv]
// Self-checking bench: register traffic through the station model.
// Assumes the slave answers frames addressed to the latched straps.
`default_nettype none
module mmia_mdio_slave_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [4:0] BUS_ADDRESS = 5'h0B;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        clockEnable = 1'b1;
    logic [4:0]  straps = BUS_ADDRESS;
    logic        mgmtClock, staDrive, staBit, dataOut, dataOutEnable_n, clockOutEnable;
    wire         mdioWire;
    logic [17:0] rdata;
    int          failCount = 0;
    int          checked = 0;
    int          cycles = 0;
    // Pull-up wins whenever neither side drives
    assign mdioWire = !dataOutEnable_n ? dataOut : (staDrive ? staBit : 1'b1);
    always #12.5 clock = ~clock;
    mmia_mdio_slave u_mmia_mdio_slave (
        .clock              (clock),
        .reset              (reset),
        .clockEnable        (clockEnable),
        .busAddressStraps   (straps),
        .mgmtClock          (mgmtClock),
        .mgmtDataIn         (mdioWire),
        .mgmtDataOut        (dataOut),
        .mgmtDataOutEnable_n(dataOutEnable_n),
        .clockOutEnable     (clockOutEnable)
    );
    mmia_station_model u_mmia_station_model (
        .mgmtClock(mgmtClock),
        .staDrive (staDrive),
        .staBit   (staBit),
        .mdioWire (mdioWire)
    );
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic checkEq(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        u_mmia_station_model.frame(1'b0, BUS_ADDRESS, a, d, rdata);
    endtask
    // Turnaround samples: released high, then driven zero
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        u_mmia_station_model.frame(1'b1, BUS_ADDRESS, a, 16'h0000, rdata);
        checkEq(rdata, {2'h2, exp});
    endtask
    task automatic setup(input logic [1:0] func, input logic [15:0] addr);
        wr(5'h0D, 16'h001F);
        wr(5'h0E, addr);
        wr(5'h0D, {func, 14'h001F});
    endtask
    task automatic addrIs(input logic [15:0] exp);
        wr(5'h0D, 16'h001F);
        rd(5'h0E, exp);
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            failCount++;
            reportAndStop();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        #1 reset = 1'b0;
        @(posedge clock);
        // Later strap changes must not move the latched address
        #1 straps = 5'h0C;
        #300;
        wr(5'h03, 16'h1234);
        rd(5'h03, 16'h1234);
        u_mmia_station_model.frame(1'b0, 5'h0C, 5'h03, 16'hDEAD, rdata);
        u_mmia_station_model.frame(1'b1, 5'h0C, 5'h03, 16'h0000, rdata);
        checkEq(rdata, 18'h3FFFF);
        rd(5'h03, 16'h1234);
        rd(5'h0D, 16'h0000);
        setup(2'h0, 16'h0170);
        rd(5'h0E, 16'h0170);
        wr(5'h0D, 16'h401F);
        rd(5'h0E, 16'h0C10);
        checkEq(18'(clockOutEnable), 18'h00001);
        wr(5'h0E, 16'h0C50);
        checkEq(18'(clockOutEnable), 18'h00000);
        rd(5'h0E, 16'h0C50);
        addrIs(16'h0170);
        setup(2'h2, 16'h0150);
        wr(5'h0E, 16'hA5A1);
        wr(5'h0E, 16'hA5A2);
        setup(2'h2, 16'h0150);
        rd(5'h0E, 16'hA5A1);
        rd(5'h0E, 16'hA5A2);
        addrIs(16'h0152);
        setup(2'h3, 16'h0151);
        rd(5'h0E, 16'hA5A2);
        rd(5'h0E, 16'hA5A2);
        wr(5'h0E, 16'h5A5B);
        addrIs(16'h0152);
        setup(2'h1, 16'h0151);
        wr(5'h0D, 16'h401E);
        wr(5'h0E, 16'hBEEF);
        rd(5'h0E, 16'h0000);
        wr(5'h0D, 16'h401F);
        rd(5'h0E, 16'h5A5B);
        setup(2'h1, 16'h0003);
        rd(5'h0E, 16'h1234);
        setup(2'h1, 16'h000D);
        wr(5'h0E, 16'hFFFF);
        rd(5'h0E, 16'h0000);
        rd(5'h0D, 16'h401F);
        reportAndStop();
    end
endmodule
`default_nettype wire

// [dv/mmia_station_model.sv]
// Station manager model: makes the management clock only within frames.
// Assumes the bench resolves the shared data line with its pull-up.
`default_nettype none
module mmia_station_model (
    // Link
    output logic      mgmtClock,
    output logic      staDrive,
    output logic      staBit,
    input  wire logic mdioWire
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        mgmtClock = 1'b0;
        staDrive = 1'b0;
        staBit = 1'b1;
    end
    // Late sample: the device answers through a synchroniser
    task automatic bit_cycle(input logic drv, input logic val, output logic got);
        staDrive = drv;
        staBit = val;
        #100 mgmtClock = 1'b1;
        #50 got = mdioWire;
        #50 mgmtClock = 1'b0;
    endtask
    task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] regAddr,
                         input logic [15:0] wdata, output logic [17:0] rdata);
        logic [35:0] bits;
        logic        got;
        bits = {4'hF, 2'h1, rd ? 2'h2 : 2'h1, phy, regAddr, rd ? 2'h3 : 2'h2, wdata};
        rdata = 18'h00000;
        // A whole system period keeps changes on the same offset from the clock
        #25;
        for (int i = 35; i >= 0; i--) begin
            bit_cycle(!(rd && i < 18), bits[i], got);
            rdata = {rdata[16:0], got};
        end
        staDrive = 1'b0;
    endtask
endmodule
`default_nettype wire
